// ===== design/cct_map.vh
// Register map, field positions and reset values of the timer channel.
// Assumes a Wishbone slave with 32-bit data, one register per aligned word.
`ifndef CCT_MAP_VH
`define CCT_MAP_VH
// Byte addresses
`define CCT_OFF_CTRL 8'h00
`define CCT_OFF_IOCTL 8'h04
`define CCT_OFF_IEN 8'h08
`define CCT_OFF_STAT 8'h0c
`define CCT_OFF_COUNT 8'h10
`define CCT_OFF_CCA 8'h14
`define CCT_OFF_CCB 8'h18
`define CCT_OFF_MODE 8'h1c
// Reset values
`define CCT_RST_CTRL 8'h80
`define CCT_RST_IOCTL 8'h88
`define CCT_RST_IEN 8'hf8
`define CCT_RST_STAT 8'hf8
`define CCT_RST_CCX 16'hffff
`define CCT_RST_MODE 8'h00
// Writable masks
`define CCT_WMASK_CTRL 8'h7f
`define CCT_WMASK_IOCTL 8'h77
`define CCT_WMASK_IEN 8'h07
// Field positions
`define CCT_CLR_HI 6
`define CCT_CLR_LO 5
`define CCT_EDGE_HI 4
`define CCT_EDGE_LO 3
`define CCT_PSC_HI 2
`define CCT_IOB_HI 6
`define CCT_IOB_LO 4
`define CCT_IOA_HI 2
`define CCT_IOA_LO 0
`define CCT_MODE_SYNC4 0
`define CCT_MODE_PHASE 1
`define CCT_MODE_PAIR_LO 4
`define CCT_MODE_PAIR_HI 5
`define CCT_FLAG_A 0
`define CCT_FLAG_B 1
`define CCT_FLAG_WRAP 2
`define CCT_COUNT_MAX 16'hffff
`endif

// ===== design/cct_sync.v
// Three-stage pin synchroniser with rise/fall pulses.
// Assumes an asynchronous pin input and the single system clock.
`timescale 1ns/1ns
module cct_sync
(
  input wire clk,
  input wire rst,
  input wire pin,
  output wire level,
  output wire rise,
  output wire fall
);
  reg [2:0] stage;
  reg prev;

  // Stage 0 is read only by stage 1
  always @(posedge clk)
  begin
    if (rst)
    begin
      stage <= 3'h0;
      prev <= 1'b0;
    end
    else
    begin
      stage <= {stage[1:0], pin};
      if (stage[2] == stage[1])
        prev <= stage[2];
    end
  end

  // A change counts once stages one and two agree
  assign level = prev;
  assign rise = (stage[2] == stage[1]) && stage[2] && !prev;
  assign fall = (stage[2] == stage[1]) && !stage[2] && prev;
endmodule // cct_sync

// ===== design/cct_prescale.v
// Prescaler giving one-cycle enables at system clock /2, /4 and /8.
// Assumes a single free-running system clock.
`timescale 1ns/1ns
module cct_prescale
(
  input wire clk,
  input wire rst,
  output wire en_div2,
  output wire en_div4,
  output wire en_div8
);
  reg [2:0] div;

  // Free-running divider
  always @(posedge clk)
  begin
    if (rst)
      div <= 3'h0;
    else
      div <= div + 3'h1;
  end

  assign en_div2 = div[0];
  assign en_div4 = (div[1:0] == 2'h3);
  assign en_div8 = (div == 3'h7);
endmodule // cct_prescale

// ===== design/cct_timer.v
// One capture/compare timer channel with a Wishbone register slave.
// Assumes classic Wishbone on MCLK, synchronous SRST, pins from outside.
`timescale 1ns/1ns
`include "cct_map.vh"

// Summary of operation
// RULE_01 - Sync bit joins counter four to group
// RULE_02 - Phase flag selects channel two phase counting
// RULE_03 - Pair code picks normal, complementary or reset PWM
// RULE_04 - Clock codes 000-011 pick internal divided clock
// RULE_05 - Clock codes 100-111 pick external input A-D
// RULE_06 - Edge select: rising, falling or both
// RULE_07 - Clear code 00 none, 01 on A event
// RULE_08 - Clear code 10 clears on B event
// RULE_09 - Clear code 11 follows group clear
// RULE_10 - Channel A compare: keep, zero, one, toggle
// RULE_11 - Channel A capture: rising, falling, both edges
// RULE_12 - Channel B compare: keep, zero, one, toggle
// RULE_13 - Channel B capture: rising, falling, both edges
// RULE_14 - Enable bit 0 gates match A request
// RULE_15 - Enable bit 1 gates match B request
// RULE_16 - Enable bit 2 gates wrap request
// RULE_17 - Match flag set on compare or capture
// RULE_18 - Flag clears by read-one then write-zero
// RULE_19 - Wrap flag set on all-ones to zero
// RULE_20 - I/O code 111 acts like 110
// RULE_21 - Reserved bits read one, ignore writes; the mode register stores all eight bits written and resets to zero
module cct_timer
(
  input wire MCLK,
  input wire SRST,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  input wire EXT_CLK_IN_A,
  input wire EXT_CLK_IN_B,
  input wire EXT_CLK_IN_C,
  input wire EXT_CLK_IN_D,
  input wire CAPTURE_IN_A,
  input wire CAPTURE_IN_B,
  input wire COUNT_RUN,
  input wire GROUP_CLEAR_IN,
  output reg COMPARE_OUT_A,
  output reg COMPARE_OUT_B,
  output reg MATCH_A_IRQ,
  output reg MATCH_B_IRQ,
  output reg WRAP_IRQ,
  output reg CLEAR_EVENT_OUT,
  output reg COUNT_FOUR_SYNC,
  output reg PHASE_COUNT_MODE,
  output reg [1:0] PAIR_MODE
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  reg [7:0] timer_control;
  reg [7:0] compare_capture_io_control;
  reg [7:0] timer_interrupt_enables;
  reg [7:0] mode_control;
  reg [15:0] count_value;
  reg [15:0] compare_capture_a;
  reg [15:0] compare_capture_b;
  reg match_a_flag, match_b_flag, wrap_flag;
  reg [2:0] flag_seen;
  reg [31:0] next_rdata;
  reg int_tick;
  reg ext_tick;
  reg [1:0] ext_rise_fall;
  wire en_div2, en_div4, en_div8;
  wire [3:0] ext_rise;
  wire [3:0] ext_fall;
  wire cap_a_rise, cap_a_fall, cap_b_rise, cap_b_fall;
  wire wb_req, wb_wr, wb_rd;
  wire tick;
  wire [2:0] io_a;
  wire [2:0] io_b;
  wire event_a, event_b, cap_a, cap_b, cmp_a, cmp_b;
  wire [1:0] clr_sel;
  wire clear_now;
  wire wrap_now;
  wire stat_wr;
  wire [7:0] wbyte;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Capture edge decode from I/O code, 111 behaving as 110
  function cap_hit;
    input [2:0] code;
    input r;
    input f;
    begin
      if (!code[2])
        cap_hit = 1'b0;
      else if (code[1])
        cap_hit = r | f; // see RULE_20
      else if (code[0])
        cap_hit = f;
      else
        cap_hit = r;
    end
  endfunction

  // Compare pin action from I/O code
  function pin_next;
    input [2:0] code;
    input cur;
    begin
      case (code[1:0])
        2'h1: pin_next = 1'b0;
        2'h2: pin_next = 1'b1;
        2'h3: pin_next = ~cur;
        default: pin_next = cur;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Clock sources and synchronisers
  cct_prescale u_psc
  (
    .clk(MCLK),
    .rst(SRST),
    .en_div2(en_div2),
    .en_div4(en_div4),
    .en_div8(en_div8)
  );

  cct_sync u_ext_a (.clk(MCLK), .rst(SRST), .pin(EXT_CLK_IN_A), .level(),
    .rise(ext_rise[0]), .fall(ext_fall[0]));
  cct_sync u_ext_b (.clk(MCLK), .rst(SRST), .pin(EXT_CLK_IN_B), .level(),
    .rise(ext_rise[1]), .fall(ext_fall[1]));
  cct_sync u_ext_c (.clk(MCLK), .rst(SRST), .pin(EXT_CLK_IN_C), .level(),
    .rise(ext_rise[2]), .fall(ext_fall[2]));
  cct_sync u_ext_d (.clk(MCLK), .rst(SRST), .pin(EXT_CLK_IN_D), .level(),
    .rise(ext_rise[3]), .fall(ext_fall[3]));
  cct_sync u_cap_a (.clk(MCLK), .rst(SRST), .pin(CAPTURE_IN_A), .level(),
    .rise(cap_a_rise), .fall(cap_a_fall));
  cct_sync u_cap_b (.clk(MCLK), .rst(SRST), .pin(CAPTURE_IN_B), .level(),
    .rise(cap_b_rise), .fall(cap_b_fall));

  // Count tick selection from the clock select and edge select fields
  always @*
  begin
    int_tick = 1'b1;
    ext_rise_fall = {ext_rise[timer_control[1:0]], ext_fall[timer_control[1:0]]};
    case (timer_control[1:0])
      2'h1: int_tick = en_div2; // see RULE_04
      2'h2: int_tick = en_div4; // see RULE_04
      2'h3: int_tick = en_div8; // see RULE_04
      default: int_tick = 1'b1; // see RULE_04
    endcase
    if (timer_control[`CCT_EDGE_HI])
      ext_tick = ext_rise_fall[1] | ext_rise_fall[0]; // see RULE_06
    else if (timer_control[`CCT_EDGE_LO])
      ext_tick = ext_rise_fall[0]; // see RULE_06
    else
      ext_tick = ext_rise_fall[1]; // see RULE_06
  end

  // External source when the top clock select bit is set
  assign tick = COUNT_RUN & (timer_control[`CCT_PSC_HI] ? ext_tick : int_tick); // see RULE_05

  ////////////////////////////////////////////////////////////////////////
  // Compare, capture and clear decode
  assign io_a = compare_capture_io_control[`CCT_IOA_HI:`CCT_IOA_LO];
  assign io_b = compare_capture_io_control[`CCT_IOB_HI:`CCT_IOB_LO];
  assign cap_a = cap_hit(io_a, cap_a_rise, cap_a_fall); // see RULE_11
  assign cap_b = cap_hit(io_b, cap_b_rise, cap_b_fall); // see RULE_13
  assign cmp_a = !io_a[2] && (count_value == compare_capture_a); // see RULE_10
  assign cmp_b = !io_b[2] && (count_value == compare_capture_b); // see RULE_12
  assign event_a = cap_a | (cmp_a & tick);
  assign event_b = cap_b | (cmp_b & tick);
  assign clr_sel = timer_control[`CCT_CLR_HI:`CCT_CLR_LO];
  assign clear_now = ((clr_sel == 2'h1) && event_a) || // see RULE_07
    ((clr_sel == 2'h2) && event_b) || // see RULE_08
    ((clr_sel == 2'h3) && GROUP_CLEAR_IN); // see RULE_09
  assign wrap_now = tick && !clear_now && (count_value == `CCT_COUNT_MAX); // see RULE_19

  ////////////////////////////////////////////////////////////////////////
  // Wishbone decode, single-cycle ack
  assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wb_wr = wb_req & WB_WE_I & WB_SEL_I[0];
  assign wb_rd = wb_req & ~WB_WE_I;
  assign wbyte = WB_DAT_I[7:0];
  assign stat_wr = wb_wr && (WB_ADR_I == `CCT_OFF_STAT);

  // Read mux
  always @*
  begin
    next_rdata = 32'h0;
    case (WB_ADR_I)
      `CCT_OFF_CTRL: next_rdata = {24'h0, timer_control};
      `CCT_OFF_IOCTL: next_rdata = {24'h0, compare_capture_io_control};
      `CCT_OFF_IEN: next_rdata = {24'h0, timer_interrupt_enables};
      `CCT_OFF_STAT: next_rdata = {24'h0, 5'h1f, wrap_flag, match_b_flag, match_a_flag};
      `CCT_OFF_COUNT: next_rdata = {16'h0, count_value};
      `CCT_OFF_CCA: next_rdata = {16'h0, compare_capture_a};
      `CCT_OFF_CCB: next_rdata = {16'h0, compare_capture_b};
      `CCT_OFF_MODE: next_rdata = {24'h0, mode_control};
      default: next_rdata = 32'h0;
    endcase
  end

  // Bus answer and control registers; reserved bits of CTRL, IOCTL and IEN held at one
  always @(posedge MCLK)
  begin
    if (SRST)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
      timer_control <= `CCT_RST_CTRL;
      compare_capture_io_control <= `CCT_RST_IOCTL;
      timer_interrupt_enables <= `CCT_RST_IEN;
      mode_control <= `CCT_RST_MODE;
    end
    else
    begin
      WB_ACK_O <= wb_req;
      if (wb_rd)
        WB_DAT_O <= next_rdata;
      if (wb_wr && WB_ADR_I == `CCT_OFF_CTRL)
        timer_control <= (wbyte & `CCT_WMASK_CTRL) | ~`CCT_WMASK_CTRL;
      if (wb_wr && WB_ADR_I == `CCT_OFF_IOCTL)
        compare_capture_io_control <= (wbyte & `CCT_WMASK_IOCTL) |
          ~`CCT_WMASK_IOCTL; // see RULE_21
      if (wb_wr && WB_ADR_I == `CCT_OFF_IEN)
        timer_interrupt_enables <= (wbyte & `CCT_WMASK_IEN) | ~`CCT_WMASK_IEN; // see RULE_21
      if (wb_wr && WB_ADR_I == `CCT_OFF_MODE)
        mode_control <= wbyte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter and general registers
  always @(posedge MCLK)
  begin
    if (SRST)
    begin
      count_value <= 16'h0;
      compare_capture_a <= `CCT_RST_CCX;
      compare_capture_b <= `CCT_RST_CCX;
    end
    else
    begin
      if (wb_wr && WB_ADR_I == `CCT_OFF_COUNT && WB_SEL_I[1])
        count_value <= WB_DAT_I[15:0];
      else if (clear_now)
        count_value <= 16'h0; // see RULE_07
      else if (tick)
        count_value <= count_value + 16'h1;
      if (cap_a)
        compare_capture_a <= count_value; // see RULE_11
      else if (wb_wr && WB_ADR_I == `CCT_OFF_CCA && WB_SEL_I[1])
        compare_capture_a <= WB_DAT_I[15:0];
      if (cap_b)
        compare_capture_b <= count_value; // see RULE_13
      else if (wb_wr && WB_ADR_I == `CCT_OFF_CCB && WB_SEL_I[1])
        compare_capture_b <= WB_DAT_I[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags: hardware set wins over software clear
  always @(posedge MCLK)
  begin
    if (SRST)
    begin
      match_a_flag <= 1'b0;
      match_b_flag <= 1'b0;
      wrap_flag <= 1'b0;
      flag_seen <= 3'h0;
    end
    else
    begin
      if (wb_rd && WB_ADR_I == `CCT_OFF_STAT)
        flag_seen <= flag_seen | {wrap_flag, match_b_flag, match_a_flag}; // see RULE_18
      else if (stat_wr)
        flag_seen <= flag_seen & wbyte[2:0];
      if (event_a)
        match_a_flag <= 1'b1; // see RULE_17
      else if (stat_wr && flag_seen[`CCT_FLAG_A] && !wbyte[`CCT_FLAG_A])
        match_a_flag <= 1'b0; // see RULE_18
      if (event_b)
        match_b_flag <= 1'b1; // see RULE_17
      else if (stat_wr && flag_seen[`CCT_FLAG_B] && !wbyte[`CCT_FLAG_B])
        match_b_flag <= 1'b0; // see RULE_18
      if (wrap_now)
        wrap_flag <= 1'b1; // see RULE_19
      else if (stat_wr && flag_seen[`CCT_FLAG_WRAP] && !wbyte[`CCT_FLAG_WRAP])
        wrap_flag <= 1'b0; // see RULE_18
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins, requests and mode outputs
  always @(posedge MCLK)
  begin
    if (SRST)
    begin
      COMPARE_OUT_A <= 1'b0;
      COMPARE_OUT_B <= 1'b0;
      MATCH_A_IRQ <= 1'b0;
      MATCH_B_IRQ <= 1'b0;
      WRAP_IRQ <= 1'b0;
      CLEAR_EVENT_OUT <= 1'b0;
      COUNT_FOUR_SYNC <= 1'b0;
      PHASE_COUNT_MODE <= 1'b0;
      PAIR_MODE <= 2'h0;
    end
    else
    begin
      if (cmp_a && tick)
        COMPARE_OUT_A <= pin_next(io_a, COMPARE_OUT_A); // see RULE_10
      if (cmp_b && tick)
        COMPARE_OUT_B <= pin_next(io_b, COMPARE_OUT_B); // see RULE_12
      MATCH_A_IRQ <= match_a_flag & timer_interrupt_enables[0]; // see RULE_14
      MATCH_B_IRQ <= match_b_flag & timer_interrupt_enables[1]; // see RULE_15
      WRAP_IRQ <= wrap_flag & timer_interrupt_enables[2]; // see RULE_16
      CLEAR_EVENT_OUT <= clear_now && (clr_sel != 2'h3);
      COUNT_FOUR_SYNC <= mode_control[`CCT_MODE_SYNC4]; // see RULE_01
      PHASE_COUNT_MODE <= mode_control[`CCT_MODE_PHASE]; // see RULE_02
      // Codes 00 and 01 both mean normal operation
      PAIR_MODE <= mode_control[`CCT_MODE_PAIR_HI] ?
        {1'b1, mode_control[`CCT_MODE_PAIR_LO]} : 2'h0; // see RULE_03
    end
  end
endmodule // cct_timer

// ===== testbench/cct_pins.sv
// Model of the pins beyond the timer: external clocks and capture inputs.
// Assumes MCLK from the bench; every pin idles low and stands still between bursts.
`timescale 1ns/1ns
module cct_pins
(
  input wire mclk,
  output reg [3:0] ext_clk,
  output reg [1:0] cap
);
  // Idle levels
  initial
  begin
    ext_clk = 4'h0;
    cap = 2'h0;
  end

  // Toggle one clock pin n times, each level held 8 cycles for the synchroniser
  task automatic ext_edges(input int p, input int n);
    repeat (n)
    begin
      @(posedge mclk) ext_clk[p] <= ~ext_clk[p];
      repeat (7) @(posedge mclk);
    end
  endtask

  // One edge on a capture pin, then let it settle through the synchroniser
  task automatic cap_edge(input int p);
    @(posedge mclk) cap[p] <= ~cap[p];
    repeat (7) @(posedge mclk);
  endtask
endmodule // cct_pins

// ===== testbench/cct_checker.sv
// Checker for the timer channel: bus answers, reserved reads, mode outputs, masks.
// Assumes it is bound to cct_timer and sees only its ports.
`timescale 1ns/1ns
`include "cct_map.vh"
module cct_checker
(
  input wire MCLK,
  input wire SRST,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  input wire [31:0] WB_DAT_O,
  input wire WB_ACK_O,
  input wire MATCH_A_IRQ,
  input wire MATCH_B_IRQ,
  input wire WRAP_IRQ,
  input wire COUNT_FOUR_SYNC,
  input wire PHASE_COUNT_MODE,
  input wire [1:0] PAIR_MODE
);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (SRST);

  // Decoded bus answers
  wire rd = WB_ACK_O && !WB_WE_I;
  wire wr = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
  wire mode_wr = wr && WB_ADR_I == `CCT_OFF_MODE;
  wire ien_wr = wr && WB_ADR_I == `CCT_OFF_IEN;

  ////////////////////////////////////////////////////////////
  // Bus answer timing and requests after reset
  chk_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack late");
  chk_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held");
  chk_ack_req: assert property (WB_ACK_O |-> WB_CYC_I && WB_STB_I)
    else $error("stray ack");
  chk_irq_reset: assert property ($past(SRST) |-> !(MATCH_A_IRQ || MATCH_B_IRQ || WRAP_IRQ))
    else $error("request after reset");

  // Reserved bits and unmapped reads
  chk_rsv_ien: assert property (
    rd && WB_ADR_I == `CCT_OFF_IEN |-> WB_DAT_O[7:3] == 5'h1f)
    else $error("enable reserved bits");
  chk_rsv_io: assert property (
    rd && WB_ADR_I == `CCT_OFF_IOCTL |-> WB_DAT_O[7] && WB_DAT_O[3])
    else $error("io reserved bits");
  chk_unmapped_read: assert property (rd && WB_ADR_I == 8'h20 |-> WB_DAT_O == 32'h0)
    else $error("unmapped read");

  // Mode outputs follow the mode register
  chk_sync_four: assert property (
    mode_wr |-> ##2 COUNT_FOUR_SYNC == $past(WB_DAT_I[0], 2))
    else $error("sync four output");
  chk_phase_mode: assert property (
    mode_wr |-> ##2 PHASE_COUNT_MODE == $past(WB_DAT_I[1], 2))
    else $error("phase output");
  chk_pair_mode: assert property (
    mode_wr |-> ##2 PAIR_MODE[1] == $past(WB_DAT_I[5], 2))
    else $error("pair output");

  // Requests are low three cycles after a write that clears their enable
  chk_mask_a: assert property (ien_wr && !WB_DAT_I[0] |-> ##3 !MATCH_A_IRQ)
    else $error("match a unmasked");
  chk_mask_b: assert property (ien_wr && !WB_DAT_I[1] |-> ##3 !MATCH_B_IRQ)
    else $error("match b unmasked");
  chk_mask_wrap: assert property (ien_wr && !WB_DAT_I[2] |-> ##3 !WRAP_IRQ)
    else $error("wrap unmasked");

  // Main scenarios reached
  cov_mode: cover property (mode_wr);
  cov_wrap: cover property (WRAP_IRQ);
  cov_match_b: cover property (MATCH_B_IRQ);
endmodule // cct_checker

bind cct_timer cct_checker chk (
  .MCLK(MCLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .MATCH_A_IRQ(MATCH_A_IRQ), .MATCH_B_IRQ(MATCH_B_IRQ),
  .WRAP_IRQ(WRAP_IRQ), .COUNT_FOUR_SYNC(COUNT_FOUR_SYNC),
  .PHASE_COUNT_MODE(PHASE_COUNT_MODE), .PAIR_MODE(PAIR_MODE)
);

// ===== testbench/tb_top.sv
// Bench for the timer channel: register table, counting, compare, capture, clears.
// Assumes the design files, the pin model and the checker are compiled before it.
`timescale 1ns/1ns
`include "cct_map.vh"
module tb_top;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d;} cct_row_t;
  reg mclk = 0, srst = 1, cyc = 0, stb = 0, we = 0, run = 0, gclr = 0;
  reg [7:0] adr = 8'h00;
  reg [3:0] sel = 4'h0;
  reg [31:0] wdat = 32'h0, rdat, e;
  wire [31:0] dat_o;
  wire ack, cmp_a, cmp_b, irq_a, irq_b, irq_w, sync4, phase, clr_ev;
  wire [1:0] pair, cap;
  wire [3:0] ext;
  logic s;
  int bad_count = 0, checked = 0, i, k, pulses;
  int oc[4] = '{2, 0, 1, 3};
  int ec[3] = '{3, 2, 5};
  // Reads carry the expected value, writes the value written
  cct_row_t rows[19] = '{'{0, 8'h00, 32'h80}, '{0, 8'h04, 32'h88}, '{0, 8'h08, 32'hf8},
    '{0, 8'h0c, 32'hf8}, '{0, 8'h10, 32'h0}, '{0, 8'h14, 32'hffff}, '{0, 8'h18, 32'hffff},
    '{0, 8'h1c, 32'h0}, '{0, 8'h20, 32'h0}, '{1, 8'h08, 32'h0}, '{0, 8'h08, 32'hf8},
    '{1, 8'h04, 32'hff}, '{0, 8'h04, 32'hff}, '{1, 8'h00, 32'h7f}, '{0, 8'h00, 32'hff},
    '{1, 8'h0c, 32'hff}, '{0, 8'h0c, 32'hf8}, '{1, 8'h20, 32'hff}, '{0, 8'h20, 32'h0}};

  // Clock at 10 MHz
  always #50 mclk = ~mclk;

  cct_pins pins (.mclk(mclk), .ext_clk(ext), .cap(cap));
  cct_timer dut (.MCLK(mclk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .EXT_CLK_IN_A(ext[0]), .EXT_CLK_IN_B(ext[1]), .EXT_CLK_IN_C(ext[2]),
    .EXT_CLK_IN_D(ext[3]), .CAPTURE_IN_A(cap[0]), .CAPTURE_IN_B(cap[1]), .COUNT_RUN(run),
    .GROUP_CLEAR_IN(gclr), .COMPARE_OUT_A(cmp_a), .COMPARE_OUT_B(cmp_b),
    .MATCH_A_IRQ(irq_a), .MATCH_B_IRQ(irq_b), .WRAP_IRQ(irq_w), .CLEAR_EVENT_OUT(clr_ev),
    .COUNT_FOUR_SYNC(sync4), .PHASE_COUNT_MODE(phase), .PAIR_MODE(pair));

  ////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One classic Wishbone cycle; read data taken at the edge that sees ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do
    begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    if (n >= 20)
    begin
      chk("ack", 0, 1);
      results();
    end
    cyc <= 0;
    stb <= 0;
  endtask

  // Hang guard
  initial
  begin
    tick(60000);
    chk("timeout", 0, 1);
    results();
  end

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    tick(2);
    srst <= 0;
    for (i = 0; i < 19; i++)
    begin
      wb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk("reg", rdat, rows[i].d);
    end
    $display("test registers done");
    for (i = 0; i < 4; i++)
    begin
      wb(1, `CCT_OFF_CTRL, i);
      wb(1, `CCT_OFF_COUNT, 0);
      run <= 1;
      tick(64);
      run <= 0;
      wb(0, `CCT_OFF_COUNT, 0);
      chk("rate", rdat + 2 >= (64 >> i) && rdat <= (64 >> i) + 2, 1);
    end
    $display("test internal clock done");
    for (i = 0; i < 12; i++)
    begin
      wb(1, `CCT_OFF_CTRL, 4 + i % 4 + (i / 4) * 8);
      wb(1, `CCT_OFF_COUNT, 0);
      run <= 1;
      pins.ext_edges((i + 1) % 4, 2);
      pins.ext_edges(i % 4, 5);
      run <= 0;
      pins.ext_edges(i % 4, 1);
      wb(0, `CCT_OFF_COUNT, 0);
      chk("ext count", rdat, ec[i / 4]);
    end
    $display("test external clock done");
    for (i = 0; i < 8; i++)
    begin
      k = i / 4;
      if (i % 4 == 0)
      begin
        wb(1, `CCT_OFF_CTRL, k ? 32'h40 : 32'h20);
        wb(1, `CCT_OFF_CCA + 4 * k, 9);
        wb(1, `CCT_OFF_COUNT, 0);
        run <= 1;
      end
      wb(1, `CCT_OFF_IOCTL, oc[i % 4] << 4 * k);
      tick(30);
      s = k ? cmp_b : cmp_a;
      if (i % 4 != 3)
        chk("pin", s, i % 4 == 2 ? 0 : 1);
      else
      begin
        // One match period: one toggle and one clear pulse to the group
        pulses = 0;
        repeat (10)
        begin
          @(posedge mclk);
          pulses += clr_ev;
        end
        chk("toggle", k ? cmp_b : cmp_a, !s);
        chk("clear out", pulses, 1);
        wb(0, `CCT_OFF_COUNT, 0);
        chk("clear", rdat <= 9, 1);
        chk("masked", k ? irq_b : irq_a, 0);
        wb(1, `CCT_OFF_IEN, 1 << k);
        tick(3);
        chk("unmasked", k ? irq_b : irq_a, 1);
        run <= 0;
        wb(1, `CCT_OFF_STAT, 32'hff);
        wb(0, `CCT_OFF_STAT, 0);
        chk("flag", rdat[k], 1);
        wb(1, `CCT_OFF_STAT, 0);
        wb(0, `CCT_OFF_STAT, 0);
        chk("flag clr", rdat[k], 0);
      end
    end
    $display("test compare done");
    wb(1, `CCT_OFF_CTRL, 0);
    wb(1, `CCT_OFF_IEN, 4);
    wb(1, `CCT_OFF_COUNT, 32'hfffd);
    run <= 1;
    tick(6);
    run <= 0;
    wb(0, `CCT_OFF_STAT, 0);
    chk("wrap flag", rdat[2], 1);
    chk("wrap irq", irq_w, 1);
    $display("test wrap done");
    for (i = 0; i < 8; i++)
    begin
      k = i / 4;
      wb(1, `CCT_OFF_IOCTL, (4 + i % 4) << 4 * k);
      wb(1, `CCT_OFF_CCA + 4 * k, 0);
      wb(1, `CCT_OFF_COUNT, 32'h1234);
      pins.cap_edge(k);
      wb(0, `CCT_OFF_CCA + 4 * k, 0);
      e = i % 4 == 1 ? 32'h0 : 32'h1234;
      chk("cap rise", rdat, e);
      wb(1, `CCT_OFF_COUNT, 32'h5678);
      pins.cap_edge(k);
      wb(0, `CCT_OFF_CCA + 4 * k, 0);
      chk("cap fall", rdat, i % 4 ? 32'h5678 : e);
    end
    $display("test capture done");
    wb(1, `CCT_OFF_CTRL, 32'h60);
    wb(1, `CCT_OFF_COUNT, 32'h100);
    run <= 1;
    gclr <= 1;
    tick(1);
    gclr <= 0;
    run <= 0;
    wb(0, `CCT_OFF_COUNT, 0);
    chk("group clr", rdat < 8, 1);
    $display("test group clear done");
    for (i = 0; i < 4; i++)
    begin
      wb(1, `CCT_OFF_MODE, i << 4 | i);
      tick(2);
      chk("pair", pair, i == 1 ? 0 : i);
      chk("sync4", sync4, i & 1);
      chk("phase", phase, i >> 1);
    end
    $display("test mode done");
    srst <= 1;
    tick(2);
    srst <= 0;
    chk("pair rst", pair, 0);
    wb(0, `CCT_OFF_CTRL, 0);
    chk("ctrl rst", rdat, 32'h80);
    $display("test reset done");
    results();
  end
endmodule // tb_top
